// >>> design/adc_seq_pkg.sv
// Shared constants and types for the converter sequencer and its controller
package adc_seq_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned CONV_TICKS = 65;
	localparam int unsigned SYNC_TICKS = 4;
	localparam int unsigned ACQ_DONE_TICKS = 15;
	localparam int unsigned EOC_LOW_TICKS = 4;
	localparam int unsigned CAL_TICKS = 1443840;
	localparam int unsigned STUCK_CYCLES = 8;
	localparam int unsigned EXT_DIV = 4;
	localparam int unsigned HOLD_EXTRA_NS = 50;
	localparam int unsigned HOLD_EXTRA_CYCLES =
		(HOLD_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_CYCLES = EXT_DIV + HOLD_EXTRA_CYCLES;
	localparam int unsigned ACQ_NS = 2250;
	localparam int unsigned ACQ_MIN_TICKS = 6;
	localparam int unsigned ACQ_CYCLES = ACQ_MIN_TICKS * EXT_DIV
		+ (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_PULSE_CYCLES = 8;
	localparam int unsigned READ_CYCLES = 4;

	// ------------------------------------------------------------
	// Device pin positions in the synchroniser vector
	// ------------------------------------------------------------
	localparam int unsigned PIN_MCLK = 0;
	localparam int unsigned PIN_HOLD_N = 1;
	localparam int unsigned PIN_CS_N = 2;
	localparam int unsigned PIN_RD_N = 3;
	localparam int unsigned PIN_RSEL = 4;
	localparam int unsigned PIN_BURST = 5;
	localparam int unsigned PIN_INTERLEAVE_CALIBRATE_N_N = 6;
	localparam int unsigned PIN_HW_RST = 7;

	// ------------------------------------------------------------
	// Device status byte
	// ------------------------------------------------------------
	localparam int unsigned SB_EOC_N = 0;
	localparam int unsigned SB_ACQ_N = 3;
	localparam int unsigned SB_TRACK = 5;
	localparam int unsigned SB_CONV = 6;
	localparam int unsigned SB_CAL = 7;

	// ------------------------------------------------------------
	// Controller registers
	// ------------------------------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] CMD_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	localparam logic [11:0] DATA_OFS = 12'h00c;
	localparam int unsigned CTRL_EXT_CLK = 0;
	localparam int unsigned CTRL_LOOPBACK = 1;
	localparam int unsigned CTRL_AUTO = 2;
	localparam int unsigned CTRL_BURST = 3;
	localparam int unsigned CTRL_INTERLEAVE_CALIBRATE_N_N = 4;
	localparam logic [4:0] CTRL_RESET = 5'h10;
	localparam int unsigned CMD_CONVERT = 0;
	localparam int unsigned CMD_SOFT_RST = 1;
	localparam int unsigned CMD_HW_RST = 2;
	localparam int unsigned CMD_READ = 3;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_EOC_N = 1;
	localparam int unsigned STAT_ACQ_N = 2;
	localparam int unsigned STAT_ACQ_OK = 3;
	localparam int unsigned STAT_PENDING = 4;

	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		DS_CAL = 4'b0001,
		DS_TRACK = 4'b0010,
		DS_SYNC = 4'b0100,
		DS_CONV = 4'b1000
	} dev_state_t;

	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_HOLD = 5'b00010,
		HS_SRST = 5'b00100,
		HS_HRST = 5'b01000,
		HS_READ = 5'b10000
	} host_state_t;

endpackage

// >>> design/adc_link_if.sv
// Pin-level link between the converter sequencer and its controller
`timescale 1ns/100ps
interface adc_link_if;
	logic master_clock_input;
	logic hold_n;
	logic chip_select_n;
	logic read_n;
	logic register_select;
	logic burst_calibrate;
	logic interleave_calibrate_n;
	logic hw_reset;
	logic eoc_n;
	logic acquisition_done_n;
	logic [15:0] data;
	logic data_oe_n;

	modport device (
		input master_clock_input, hold_n, chip_select_n, read_n,
		input register_select, burst_calibrate, interleave_calibrate_n,
		input hw_reset,
		output eoc_n, acquisition_done_n, data, data_oe_n
	);

	modport host (
		output master_clock_input, hold_n, chip_select_n, read_n,
		output register_select, burst_calibrate, interleave_calibrate_n,
		output hw_reset,
		input eoc_n, acquisition_done_n, data, data_oe_n
	);
endinterface

// >>> design/adc_sequencer.sv
// Converter-side sequencing: clock source, conversion, reset and calibration
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps

// What this block does
// - Internal clock when master input held low
// - Falling hold freezes input, starts conversion
// - Controller keeps hold low period plus 50ns
// - Return to tracking after conversion, unprompted
// - Controller releases hold before conversion ends
// - Bus-driven hold uses register select high
// - Calibration inputs latched by chip select
// - Controller waits six periods plus 2.25us
// - Quarter-rate clock, start delayed up to four
// - Acquisition done falls 15 periods after EOC
// - Loopback: 65-period conversion, 80-period rate
// - Controller counter restarts conversion after acquisition
// - Hardware reset clears, then full calibration
// - Reset overrides conversion and calibration
// - Software reset: select, register select, hold low
// - EOC high during reset, falls when done
// - Controller waits acquisition after reset EOC
// - Stand-alone wiring keeps EOC high after reset
// - Calibration trims each bit against lower sum
// - EOC low until a read or start, then high four periods later
module adc_sequencer #(
	parameter int unsigned CAL_TICKS = adc_seq_pkg::CAL_TICKS
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Link pins
	adc_link_if.device link,
	// Analog front end stand-in
	input wire logic [15:0] sample_in,
	// Status towards the user
	output logic [15:0] conv_result,
	output logic calibrating,
	output logic converting,
	output logic tracking,
	output logic ext_clock_active,
	output logic burst_latched,
	output logic interleave_latched_n
);

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic mclk_prev;
		logic [3:0] stuck;
		logic ext;
		logic cs_prev;
		logic burst;
		logic interleave_calibrate_n_n;
		adc_seq_pkg::dev_state_t st;
		logic [1:0] phase;
		logic [20:0] cnt;
		logic acq_run;
		logic [3:0] acq_cnt;
		logic acq_n;
		logic eoc_n;
		logic eoc_rel;
		logic [1:0] eoc_cnt;
		logic [15:0] held;
		logic [15:0] result;
		logic [15:0] data;
		logic data_oe_n;
	} dev_regs_t;

	dev_regs_t q, n;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic [7:0] pins;
	logic rise, tick, hw_rst, sw_rst, rd_act, alone, start, cs_rise;
	logic [7:0] sbyte;

	always_comb begin
		pins = '0;
		pins[adc_seq_pkg::PIN_MCLK] = link.master_clock_input;
		pins[adc_seq_pkg::PIN_HOLD_N] = link.hold_n;
		pins[adc_seq_pkg::PIN_CS_N] = link.chip_select_n;
		pins[adc_seq_pkg::PIN_RD_N] = link.read_n;
		pins[adc_seq_pkg::PIN_RSEL] = link.register_select;
		pins[adc_seq_pkg::PIN_BURST] = link.burst_calibrate;
		pins[adc_seq_pkg::PIN_INTERLEAVE_CALIBRATE_N_N] = link.interleave_calibrate_n;
		pins[adc_seq_pkg::PIN_HW_RST] = link.hw_reset;
		rise = q.s2[adc_seq_pkg::PIN_MCLK] & ~q.mclk_prev;
		tick = q.ext ? rise : 1'b1;
		hw_rst = q.s2[adc_seq_pkg::PIN_HW_RST];
		sw_rst = ~q.s2[adc_seq_pkg::PIN_CS_N] & ~q.s2[adc_seq_pkg::PIN_RSEL]
			& ~q.s2[adc_seq_pkg::PIN_HOLD_N];
		rd_act = ~q.s2[adc_seq_pkg::PIN_CS_N] & ~q.s2[adc_seq_pkg::PIN_RD_N];
		alone = rd_act & q.s2[adc_seq_pkg::PIN_RSEL];
		cs_rise = q.s2[adc_seq_pkg::PIN_CS_N] & ~q.cs_prev;
		start = 1'b0;
		sbyte = '0;
		sbyte[adc_seq_pkg::SB_EOC_N] = q.eoc_n;
		sbyte[adc_seq_pkg::SB_ACQ_N] = q.acq_n;
		sbyte[adc_seq_pkg::SB_TRACK] = q.st == adc_seq_pkg::DS_TRACK;
		sbyte[adc_seq_pkg::SB_CONV] = q.st == adc_seq_pkg::DS_CONV
			|| q.st == adc_seq_pkg::DS_SYNC;
		sbyte[adc_seq_pkg::SB_CAL] = q.st == adc_seq_pkg::DS_CAL;
		n = q;
		if (ce) begin
			n.s1 = pins;
			n.s2 = q.s1;
			n.mclk_prev = q.s2[adc_seq_pkg::PIN_MCLK];
			n.cs_prev = q.s2[adc_seq_pkg::PIN_CS_N];
			// A master clock that stops low hands over to the oscillator
			if (rise) begin
				n.ext = 1'b1;
				n.stuck = '0;
			end else if (q.stuck != 4'(adc_seq_pkg::STUCK_CYCLES)) begin
				n.stuck = q.stuck + 4'h1;
			end else begin
				n.ext = 1'b0;
			end
			if (cs_rise) begin
				n.burst = q.s2[adc_seq_pkg::PIN_BURST];
				n.interleave_calibrate_n_n = q.s2[adc_seq_pkg::PIN_INTERLEAVE_CALIBRATE_N_N];
			end
			n.data_oe_n = ~rd_act;
			n.data = q.s2[adc_seq_pkg::PIN_RSEL] ? q.result : {8'h00, sbyte};
			if (hw_rst || sw_rst) begin
				// Held in the cleared state for as long as the reset lasts
				n.st = adc_seq_pkg::DS_CAL;
				n.cnt = '0;
				n.phase = '0;
				n.acq_run = 1'b0;
				n.acq_cnt = '0;
				n.acq_n = 1'b1;
				n.eoc_n = 1'b1;
				n.eoc_rel = 1'b0;
				n.eoc_cnt = '0;
			end else if (tick) begin
				n.phase = q.phase + 2'h1;
				if (q.acq_run) begin
					if (q.acq_cnt == 4'(adc_seq_pkg::ACQ_DONE_TICKS - 1)) begin
						n.acq_n = 1'b0;
						n.acq_run = 1'b0;
					end else begin
						n.acq_cnt = q.acq_cnt + 4'h1;
					end
				end
				case (q.st)
					adc_seq_pkg::DS_CAL: begin
						// Each step stands for one trim experiment on a bit
						// weight against the lower weights plus a dummy LSB
						n.cnt = q.cnt + 21'h1;
						if (q.cnt == 21'(CAL_TICKS - 1)) begin
							n.st = adc_seq_pkg::DS_TRACK;
							n.cnt = '0;
							n.eoc_n = alone;
							n.acq_run = 1'b1;
							n.acq_cnt = '0;
						end
					end
					adc_seq_pkg::DS_TRACK: begin
						// Level sensed: a strobe still low here restarts
						if (~q.s2[adc_seq_pkg::PIN_HOLD_N]) begin
							n.held = sample_in;
							if (~q.acq_n) begin
								// Aligned to the conversion clock, no wait
								start = 1'b1;
							end else begin
								n.st = adc_seq_pkg::DS_SYNC;
							end
						end
					end
					adc_seq_pkg::DS_SYNC: begin
						if (q.phase == 2'(adc_seq_pkg::SYNC_TICKS - 1)) begin
							start = 1'b1;
						end
					end
					adc_seq_pkg::DS_CONV: begin
						n.cnt = q.cnt + 21'h1;
						if (q.cnt == 21'(adc_seq_pkg::CONV_TICKS - 1)) begin
							n.st = adc_seq_pkg::DS_TRACK;
							n.cnt = '0;
							n.result = q.held;
							n.eoc_n = 1'b0;
							n.eoc_rel = 1'b0;
							n.eoc_cnt = '0;
							n.acq_run = 1'b1;
							n.acq_cnt = '0;
						end
					end
					default: begin
						n.st = adc_seq_pkg::DS_CAL;
						n.cnt = '0;
					end
				endcase
				if (start) begin
					n.st = adc_seq_pkg::DS_CONV;
					n.cnt = '0;
					n.phase = '0;
					n.acq_n = 1'b1;
					n.acq_run = 1'b0;
				end
				// EOC returns high four periods after a read or a start; it
				// is back high long before a conversion ends and falls again
				if (~q.eoc_n) begin
					n.eoc_rel = q.eoc_rel | rd_act | start;
					if (q.eoc_rel) begin
						n.eoc_cnt = q.eoc_cnt + 2'h1;
						if (q.eoc_cnt == 2'(adc_seq_pkg::EOC_LOW_TICKS - 1)) begin
							n.eoc_n = 1'b1;
							n.eoc_rel = 1'b0;
							n.eoc_cnt = '0;
						end
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Synchronisers start at idle pin levels: no false strobe
			q <= '{s1: 8'h5e, s2: 8'h5e, mclk_prev: 1'b0, stuck: 4'h0,
				ext: 1'b0, cs_prev: 1'b1, burst: 1'b0, interleave_calibrate_n_n: 1'b1,
				st: adc_seq_pkg::DS_CAL, phase: 2'h0, cnt: 21'h0,
				acq_run: 1'b0, acq_cnt: 4'h0, acq_n: 1'b1, eoc_n: 1'b1,
				eoc_rel: 1'b0, eoc_cnt: 2'h0, held: 16'h0000,
				result: 16'h0000, data: 16'h0000, data_oe_n: 1'b1};
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.eoc_n = q.eoc_n;
	assign link.acquisition_done_n = q.acq_n;
	assign link.data = q.data;
	assign link.data_oe_n = q.data_oe_n;
	assign conv_result = q.result;
	// One-hot states, so each flag is a state bit straight from the flop
	assign calibrating = q.st[0];
	assign converting = q.st[3];
	assign tracking = q.st[1];
	assign ext_clock_active = q.ext;
	assign burst_latched = q.burst;
	assign interleave_latched_n = q.interleave_calibrate_n_n;

endmodule

// >>> design/adc_controller.sv
// Controller end: APB registers driving the converter pins
`timescale 1ns/100ps
module adc_controller (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link pins
	adc_link_if.host link
);

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [4:0] ctrl;
		logic [3:0] pend;
		adc_seq_pkg::host_state_t st;
		logic [8:0] cnt;
		logic [8:0] acq;
		logic [1:0] div;
		logic mclk;
		logic hold_n;
		logic cs_n;
		logic rd_n;
		logic rsel;
		logic burst;
		logic interleave_calibrate_n_n;
		logic hw_rst;
		logic eoc_prev;
		logic [15:0] data;
	} host_regs_t;

	host_regs_t q, n;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic access, done, acq_ok, eoc_fall;
	logic [31:0] rdv;
	logic [31:0] stat;

	always_comb begin
		access = psel & penable & ~q.pready;
		done = psel & penable & q.pready;
		acq_ok = q.acq == 9'(adc_seq_pkg::ACQ_CYCLES);
		// The device end registers its pins on this clock: read directly
		eoc_fall = ~link.eoc_n & q.eoc_prev;
		stat = '0;
		stat[adc_seq_pkg::STAT_BUSY] = q.st != adc_seq_pkg::HS_IDLE;
		stat[adc_seq_pkg::STAT_EOC_N] = link.eoc_n;
		stat[adc_seq_pkg::STAT_ACQ_N] = link.acquisition_done_n;
		stat[adc_seq_pkg::STAT_ACQ_OK] = acq_ok;
		stat[adc_seq_pkg::STAT_PENDING] = |q.pend;
		case (paddr)
			adc_seq_pkg::CTRL_OFS: rdv = {27'h0, q.ctrl};
			adc_seq_pkg::STATUS_OFS: rdv = stat;
			adc_seq_pkg::DATA_OFS: rdv = {16'h0000, q.data};
			default: rdv = '0;
		endcase
		n = q;
		if (ce) begin
			n.eoc_prev = link.eoc_n;
			n.pready = access;
			if (access) begin
				n.prdata = rdv;
				n.pslverr = paddr != adc_seq_pkg::CTRL_OFS
					&& paddr != adc_seq_pkg::CMD_OFS
					&& paddr != adc_seq_pkg::STATUS_OFS
					&& paddr != adc_seq_pkg::DATA_OFS;
			end
			if (done && pwrite && paddr == adc_seq_pkg::CTRL_OFS) begin
				n.ctrl = pwdata[4:0];
			end
			if (done && pwrite && paddr == adc_seq_pkg::CMD_OFS) begin
				n.pend = q.pend | pwdata[3:0];
			end
			// Master clock out, or held low to select the oscillator
			n.div = q.div + 2'h1;
			n.mclk = q.ctrl[adc_seq_pkg::CTRL_EXT_CLK] & q.div[1];
			// Acquisition counter restarts on every EOC fall
			if (eoc_fall) begin
				n.acq = '0;
			end else if (!acq_ok) begin
				n.acq = q.acq + 9'h1;
			end
			if (q.ctrl[adc_seq_pkg::CTRL_AUTO] && acq_ok && eoc_fall == 1'b0
				&& q.st == adc_seq_pkg::HS_IDLE && q.hold_n) begin
				n.pend[adc_seq_pkg::CMD_CONVERT] = 1'b1;
			end
			n.cnt = q.cnt + 9'h1;
			case (q.st)
				adc_seq_pkg::HS_IDLE: begin
					n.cnt = '0;
					n.cs_n = 1'b1;
					n.rd_n = 1'b1;
					n.rsel = 1'b1;
					n.hw_rst = 1'b0;
					// Calibration levels only change while deselected
					n.burst = q.ctrl[adc_seq_pkg::CTRL_BURST];
					n.interleave_calibrate_n_n = q.ctrl[adc_seq_pkg::CTRL_INTERLEAVE_CALIBRATE_N_N];
					n.hold_n = q.ctrl[adc_seq_pkg::CTRL_LOOPBACK]
						? link.acquisition_done_n : 1'b1;
					if (q.pend[adc_seq_pkg::CMD_HW_RST]) begin
						n.pend[adc_seq_pkg::CMD_HW_RST] = 1'b0;
						n.hw_rst = 1'b1;
						n.st = adc_seq_pkg::HS_HRST;
					end else if (q.pend[adc_seq_pkg::CMD_SOFT_RST]) begin
						n.pend[adc_seq_pkg::CMD_SOFT_RST] = 1'b0;
						n.cs_n = 1'b0;
						n.rsel = 1'b0;
						n.hold_n = 1'b0;
						n.st = adc_seq_pkg::HS_SRST;
					end else if (q.pend[adc_seq_pkg::CMD_READ]) begin
						n.pend[adc_seq_pkg::CMD_READ] = 1'b0;
						n.cs_n = 1'b0;
						n.rd_n = 1'b0;
						n.st = adc_seq_pkg::HS_READ;
					end else if (q.pend[adc_seq_pkg::CMD_CONVERT] && acq_ok
						&& !q.ctrl[adc_seq_pkg::CTRL_LOOPBACK]) begin
						// Wait out acquisition after every EOC fall
						n.pend[adc_seq_pkg::CMD_CONVERT] = 1'b0;
						n.cs_n = 1'b0;
						n.rsel = 1'b1;
						n.hold_n = 1'b0;
						n.st = adc_seq_pkg::HS_HOLD;
					end
				end
				adc_seq_pkg::HS_HOLD, adc_seq_pkg::HS_SRST: begin
					// Long enough to be seen, far short of a conversion
					if (q.cnt == 9'(adc_seq_pkg::HOLD_CYCLES - 1)) begin
						n.hold_n = 1'b1;
						n.cs_n = 1'b1;
						n.rsel = 1'b1;
						n.st = adc_seq_pkg::HS_IDLE;
					end
				end
				adc_seq_pkg::HS_READ: begin
					if (q.cnt == 9'(adc_seq_pkg::READ_CYCLES - 1)) begin
						n.data = link.data;
						n.cs_n = 1'b1;
						n.rd_n = 1'b1;
						n.st = adc_seq_pkg::HS_IDLE;
					end
				end
				adc_seq_pkg::HS_HRST: begin
					if (q.cnt == 9'(adc_seq_pkg::RST_PULSE_CYCLES - 1)) begin
						n.hw_rst = 1'b0;
						n.st = adc_seq_pkg::HS_IDLE;
					end
				end
				default: begin
					n.st = adc_seq_pkg::HS_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
				ctrl: adc_seq_pkg::CTRL_RESET, pend: 4'h0,
				st: adc_seq_pkg::HS_IDLE, cnt: 9'h000, acq: 9'h000,
				div: 2'h0, mclk: 1'b0, hold_n: 1'b1, cs_n: 1'b1,
				rd_n: 1'b1, rsel: 1'b1, burst: 1'b0, interleave_calibrate_n_n: 1'b1,
				hw_rst: 1'b0, eoc_prev: 1'b1, data: 16'h0000};
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign link.master_clock_input = q.mclk;
	assign link.hold_n = q.hold_n;
	assign link.chip_select_n = q.cs_n;
	assign link.read_n = q.rd_n;
	assign link.register_select = q.rsel;
	assign link.burst_calibrate = q.burst;
	assign link.interleave_calibrate_n = q.interleave_calibrate_n_n;
	assign link.hw_reset = q.hw_rst;

endmodule

// >>> sim/adc_link_properties.sv
// Temporal checks on the pins between the converter and its controller
`timescale 1ns/100ps
module adc_link_properties (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link pins
	input wire logic master_clock_input,
	input wire logic hold_n,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic register_select,
	input wire logic hw_reset,
	input wire logic eoc_n,
	input wire logic acquisition_done_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Cycles since end of conversion
	// ------------------------------------------------------------
	logic [9:0] since_q;
	logic [9:0] since_d;
	logic eoc_q;
	// Saturates so a long idle spell never wraps into a false short one
	always_comb begin
		since_d = since_q;
		if (since_q != 10'h3ff)
			since_d = since_q + 10'h001;
		if (eoc_q && !eoc_n)
			since_d = 10'h000;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_q <= 10'h000;
			eoc_q <= 1'b1;
		end else begin
			since_q <= since_d;
			eoc_q <= eoc_n;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_hold_min_width: assert property (
		$fell(hold_n) && !chip_select_n |-> !hold_n [*8])
		else $error("hold strobe too short");
	a_hold_released: assert property (
		$fell(hold_n) && !chip_select_n |-> ##10 !hold_n ##1 hold_n)
		else $error("hold strobe not released in time");
	a_acquire_before_start: assert property (
		$fell(hold_n) && !chip_select_n && register_select
		|-> since_q >= 10'(adc_seq_pkg::ACQ_CYCLES))
		else $error("conversion started before acquisition");
	a_hw_reset_pulse: assert property (
		$rose(hw_reset) |-> hw_reset [*8] ##1 !hw_reset)
		else $error("hardware reset pulse length wrong");
	a_reset_holds_eoc: assert property (
		$rose(hw_reset) |-> ##4 eoc_n [*8])
		else $error("end of conversion low during reset");
	a_acq_after_eoc: assert property (
		$fell(acquisition_done_n) |-> !$past(eoc_n, 15) && $past(eoc_n, 16))
		else $error("acquisition done not 15 periods after eoc");
	a_eoc_low_width: assert property (
		$fell(eoc_n) |-> !eoc_n [*4])
		else $error("end of conversion pulse too short");
	a_eoc_read_clears: assert property (
		$fell(read_n) |-> ##[1:12] eoc_n)
		else $error("end of conversion stays low after read");
	a_mclk_quarter: assert property (
		$rose(master_clock_input) |-> ##2 !master_clock_input)
		else $error("master clock not a quarter of pclk");

	c_conversion: cover property ($fell(eoc_n));
	c_acquired: cover property ($fell(acquisition_done_n));
	c_hw_reset: cover property ($rose(hw_reset));
	c_data_read: cover property ($fell(read_n));
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the converter sequencer and its controller
`timescale 1ns/100ps
module testbench;
	logic pclk;
	logic presetn;
	logic ce;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] sample_in;
	logic [15:0] conv_result;
	logic calibrating;
	logic converting;
	logic tracking;
	logic ext_clock_active;
	logic burst_latched;
	logic interleave_latched_n;
	logic [3:0] mon;
	logic [31:0] rdat;
	logic err;
	logic [15:0] tab [2];
	int n_errors;
	int n_compared;
	int n;
	int c;

	adc_link_if adc_link_if_i ();
	adc_sequencer #(.CAL_TICKS(200)) adc_sequencer_i (.pclk(pclk),
		.presetn(presetn), .ce(ce), .link(adc_link_if_i.device),
		.sample_in(sample_in), .conv_result(conv_result),
		.calibrating(calibrating), .converting(converting),
		.tracking(tracking), .ext_clock_active(ext_clock_active),
		.burst_latched(burst_latched),
		.interleave_latched_n(interleave_latched_n));
	adc_controller adc_controller_i (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(adc_link_if_i.host));
	adc_link_properties adc_link_properties_i (.pclk(pclk),
		.presetn(presetn),
		.master_clock_input(adc_link_if_i.master_clock_input),
		.hold_n(adc_link_if_i.hold_n),
		.chip_select_n(adc_link_if_i.chip_select_n),
		.read_n(adc_link_if_i.read_n),
		.register_select(adc_link_if_i.register_select),
		.hw_reset(adc_link_if_i.hw_reset), .eoc_n(adc_link_if_i.eoc_n),
		.acquisition_done_n(adc_link_if_i.acquisition_done_n));
	assign mon = {calibrating, converting, tracking, adc_link_if_i.eoc_n};

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic give_up();
		n_errors++;
		$display("BAD %0t wait ran out", $time);
		tally_and_finish();
	endtask
	// One APB transfer; the idle edge after it keeps strobes single-driven
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// Looked at mid-cycle, where pready has settled
		do begin
			@(negedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		if (pready !== 1'b1)
			give_up();
		// The transfer completes at this edge; nothing moves before it
		@(posedge pclk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_mon(input int b, input logic v, input int lim,
		output int cnt);
		cnt = 0;
		// Sampled mid-cycle, then back on a rising edge for the caller
		@(negedge pclk);
		while (mon[b] !== v) begin
			@(negedge pclk);
			cnt++;
			if (cnt > lim)
				give_up();
		end
		@(posedge pclk);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sample_in = 16'h0000;
		n_errors = 0;
		n_compared = 0;
		tab[0] = 16'h1234;
		tab[1] = 16'hfedc;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, adc_seq_pkg::CTRL_OFS, 32'h0);
		check(rdat, 32'h10);
		apb(1'b0, 12'h010, 32'h0);
		check({rdat[30:0], err}, 32'h1);
		check(mon[0], 32'h1);
		wait_mon(0, 1'b0, 3000, n);
		check(n >= 190, 32'h1);
		apb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h18);
		for (int i = 0; i < 2; i++) begin
			sample_in <= tab[i];
			apb(1'b1, adc_seq_pkg::CMD_OFS, 32'h1);
			wait_mon(2, 1'b1, 1000, n);
			// A new input after the strobe must not reach the result
			sample_in <= ~tab[i];
			wait_mon(2, 1'b0, 1000, n);
			check(n >= 60 && n <= 70, 32'h1);
			check(mon[0], 32'h0);
			@(posedge pclk);
			check(conv_result, tab[i]);
			check(tracking, 32'h1);
			apb(1'b1, adc_seq_pkg::CMD_OFS, 32'h8);
			wait_mon(0, 1'b1, 50, n);
			c = 0;
			do begin
				apb(1'b0, adc_seq_pkg::STATUS_OFS, 32'h0);
				c++;
			end while ((rdat[0] | rdat[4]) !== 1'b0 && c < 20);
			apb(1'b0, adc_seq_pkg::DATA_OFS, 32'h0);
			check(rdat, {16'h0000, tab[i]});
		end
		check(burst_latched, 32'h1);
		apb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h12);
		wait_mon(0, 1'b1, 1000, n);
		wait_mon(0, 1'b0, 1000, n);
		wait_mon(0, 1'b1, 1000, c);
		wait_mon(0, 1'b0, 1000, n);
		check(n + c >= 80 && n + c <= 88, 32'h1);
		// Interleave low now, latched by the next chip-select rise
		apb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h00);
		wait_mon(2, 1'b0, 1000, n);
		wait_mon(0, 1'b0, 1000, n);
		repeat (8) @(posedge pclk);
		apb(1'b1, adc_seq_pkg::CMD_OFS, 32'h2);
		wait_mon(3, 1'b1, 100, n);
		check(mon[0], 32'h1);
		wait_mon(0, 1'b0, 3000, n);
		check(n >= 190, 32'h1);
		check(interleave_latched_n, 32'h0);
		apb(1'b1, adc_seq_pkg::CMD_OFS, 32'h1);
		wait_mon(2, 1'b1, 1000, n);
		apb(1'b1, adc_seq_pkg::CMD_OFS, 32'h4);
		wait_mon(3, 1'b1, 100, n);
		check(converting, 32'h0);
		wait_mon(0, 1'b0, 3000, n);
		// Auto mode starts on its own once acquisition has run out
		apb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h04);
		wait_mon(2, 1'b1, 1000, n);
		check(n >= 300 && n <= 312, 32'h1);
		apb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h11);
		repeat (20) @(posedge pclk);
		check(ext_clock_active, 32'h1);
		apb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h10);
		repeat (20) @(posedge pclk);
		check(ext_clock_active, 32'h0);
		tally_and_finish();
	end
endmodule
